// File: design/usfc_core.sv
// usfc_core: status flags, flag clear register, enables and the
// plain register port of the serial status block.
// assumes events are one-cycle pulses synchronous to core_clk and
// that the master never raises both strobes at once.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps

module usfc_core #(
  parameter int DATA_W = 9
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire usfc_pkg::usfc_bus_s bus,
  output logic [31:0] rd_data,
  input wire usfc_pkg::usfc_evt_s evt,
  input wire logic [DATA_W-1:0] rx_shift_word,
  output logic [DATA_W-1:0] tx_word,
  output logic tx_word_load,
  output logic tx_buffer_empty,
  output logic rx_buffer_full,
  output logic irq
);

  typedef struct packed {
    logic [31:0] int_mask;
    logic [1:0] mode;
    logic idle_armed;
    logic [DATA_W-1:0] rx_word;
    logic [DATA_W-1:0] tx_word;
    logic tx_load;
    logic [31:0] rd_data;
  } usfc_core_st_s;

  localparam usfc_core_st_s CORE_RST = '{
    int_mask: usfc_pkg::MASK_RST,
    mode: usfc_pkg::MODE_RST,
    idle_armed: usfc_pkg::IDLE_ARM_RST,
    default: '0
  };

  usfc_core_st_s st_reg;
  usfc_core_st_s st_next;
  logic [31:0] status;
  logic [31:0] set_v;
  logic [31:0] clr_v;
  logic clr_wr;
  logic cmd_wr;
  logic tx_flush;
  logic rx_flush;
  logic rx_read;
  logic tx_write;
  logic rx_move;

  if (DATA_W < 1 || DATA_W > 32) begin : g_data_chk
    $error("data width out of range");
  end

  // address match for one strobe
  function automatic logic hit(
    input logic strobe,
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    return strobe && (addr == ofs);
  endfunction : hit

  // strobe decodes
  assign clr_wr = hit(bus.wr, bus.addr, usfc_pkg::OFS_FLAG_CLEAR);
  assign cmd_wr = hit(bus.wr, bus.addr, usfc_pkg::OFS_COMMAND);
  assign tx_write = hit(bus.wr, bus.addr, usfc_pkg::OFS_TX_WORD);
  assign rx_read = hit(bus.rd, bus.addr, usfc_pkg::OFS_RX_WORD);
  assign tx_flush = cmd_wr && bus.wdata[usfc_pkg::CMD_TX_FLUSH];
  assign rx_flush = cmd_wr && bus.wdata[usfc_pkg::CMD_RX_FLUSH];

  // word moves only into an empty buffer
  assign rx_move = evt.rx_word_ready && !status[usfc_pkg::BIT_RX_FULL];

  // hardware set terms for every flag
  always_comb begin
    set_v = 32'h0;
    set_v[usfc_pkg::BIT_TX_EMPTY] = evt.tx_to_shift | tx_flush;
    set_v[usfc_pkg::BIT_TX_DONE] = evt.tx_frame_done
                                   & status[usfc_pkg::BIT_TX_EMPTY];
    set_v[usfc_pkg::BIT_RX_FULL] = rx_move;
    set_v[usfc_pkg::BIT_IDLE] = evt.idle_detect & st_reg.idle_armed;
    set_v[usfc_pkg::BIT_OVERRUN] = evt.rx_word_ready
                                   & status[usfc_pkg::BIT_RX_FULL];
    set_v[usfc_pkg::BIT_NOISE] = evt.noise_detect;
    set_v[usfc_pkg::BIT_FRAMING] = evt.desync_detect | evt.break_char
      | (evt.sc_tx_mode & evt.sc_retry_out);
    set_v[usfc_pkg::BIT_PARITY] = evt.parity_mismatch;
    // upper flags, set logic lives outside this block
    set_v[usfc_pkg::BIT_LINE_BREAK] = evt.line_break_event;
    set_v[usfc_pkg::BIT_CTS_CHANGE] = evt.cts_toggle;
    set_v[usfc_pkg::BIT_RX_TIMEOUT] = evt.rx_timeout_event;
    set_v[usfc_pkg::BIT_END_BLOCK] = evt.end_block_event;
    set_v[usfc_pkg::BIT_ADDR_MATCH] = evt.addr_match_event;
    set_v[usfc_pkg::BIT_WAKEUP] = evt.wakeup_event;
  end

  // software clear terms
  always_comb begin
    clr_v = 32'h0;
    if (clr_wr) begin
      clr_v = bus.wdata & usfc_pkg::CLEAR_MASK;
    end
    clr_v[usfc_pkg::BIT_TX_EMPTY] = tx_write;
    clr_v[usfc_pkg::BIT_RX_FULL] = rx_read | rx_flush;
  end

  // status flag storage
  usfc_flag_bank #(
    .WIDTH(32),
    .KEEP(usfc_pkg::FLAG_MASK),
    .RST(usfc_pkg::STATUS_RST)
  ) u_flags (
    .core_clk(core_clk),
    .srst(srst),
    .set_v(set_v),
    .clr_v(clr_v),
    .flags(status)
  );

  // interrupt level
  usfc_irq_gate u_irq (
    .core_clk(core_clk),
    .srst(srst),
    .status(status),
    .int_mask(st_reg.int_mask),
    .mode(st_reg.mode),
    .irq(irq)
  );

  // next state: register writes, reads, rx capture, idle arming
  always_comb begin
    st_next = st_reg;
    st_next.tx_load = 1'b0;
    st_next.rd_data = 32'h0;
    // register writes
    if (bus.wr) begin
      if (bus.addr == usfc_pkg::OFS_INT_MASK) begin
        st_next.int_mask = bus.wdata & usfc_pkg::MASK_WMASK;
      end else if (bus.addr == usfc_pkg::OFS_MODE) begin
        st_next.mode = bus.wdata[1:0];
      end else if (bus.addr == usfc_pkg::OFS_TX_WORD) begin
        st_next.tx_word = bus.wdata[DATA_W-1:0];
        st_next.tx_load = 1'b1;
      end
    end
    // read mux, clear register reads zero
    if (bus.rd) begin
      if (bus.addr == usfc_pkg::OFS_STATUS) begin
        st_next.rd_data = status;
      end else if (bus.addr == usfc_pkg::OFS_INT_MASK) begin
        st_next.rd_data = st_reg.int_mask;
      end else if (bus.addr == usfc_pkg::OFS_MODE) begin
        st_next.rd_data = {30'h0, st_reg.mode};
      end else if (bus.addr == usfc_pkg::OFS_RX_WORD) begin
        st_next.rd_data = 32'(st_reg.rx_word);
      end else begin
        st_next.rd_data = 32'h0;
      end
    end
    if (rx_move) begin
      st_next.rx_word = rx_shift_word;
    end
    // rearm idle on fresh rx full
    if (set_v[usfc_pkg::BIT_RX_FULL]) begin
      st_next.idle_armed = 1'b1;
    end else if (set_v[usfc_pkg::BIT_IDLE]) begin
      st_next.idle_armed = 1'b0;
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= CORE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign rd_data = st_reg.rd_data;
  assign tx_word = st_reg.tx_word;
  assign tx_word_load = st_reg.tx_load;
  assign tx_buffer_empty = status[usfc_pkg::BIT_TX_EMPTY];
  assign rx_buffer_full = status[usfc_pkg::BIT_RX_FULL];

  a_tx_empty_write: assert property (
    @(posedge core_clk) disable iff (srst)
    (tx_write && !evt.tx_to_shift) |=>
      !status[usfc_pkg::BIT_TX_EMPTY])
    else $error("tx empty not cleared by write");

  a_tx_empty_flush: assert property (
    @(posedge core_clk) disable iff (srst)
    tx_flush |=> status[usfc_pkg::BIT_TX_EMPTY])
    else $error("tx empty not set by flush");

  a_tx_done_set: assert property (
    @(posedge core_clk) disable iff (srst)
    (evt.tx_frame_done && status[usfc_pkg::BIT_TX_EMPTY]) |=>
      status[usfc_pkg::BIT_TX_DONE])
    else $error("tx done not set");

  a_tx_done_clear: assert property (
    @(posedge core_clk) disable iff (srst)
    (clr_wr && bus.wdata[usfc_pkg::BIT_TX_DONE]
      && !set_v[usfc_pkg::BIT_TX_DONE]) |=>
      !status[usfc_pkg::BIT_TX_DONE])
    else $error("tx done not cleared");

  a_rx_word_move: assert property (
    @(posedge core_clk) disable iff (srst)
    rx_move |=> (status[usfc_pkg::BIT_RX_FULL]
      && (st_reg.rx_word == $past(rx_shift_word))))
    else $error("rx word not taken");

  a_rx_read_clear: assert property (
    @(posedge core_clk) disable iff (srst)
    (rx_read && !rx_move) |=> !status[usfc_pkg::BIT_RX_FULL])
    else $error("rx full not cleared by read");

  a_idle_one_shot: assert property (
    @(posedge core_clk) disable iff (srst)
    (!st_reg.idle_armed && !status[usfc_pkg::BIT_IDLE]
      && !rx_move) |=> !status[usfc_pkg::BIT_IDLE])
    else $error("idle set while disarmed");

  a_overrun_set: assert property (
    @(posedge core_clk) disable iff (srst)
    (evt.rx_word_ready && status[usfc_pkg::BIT_RX_FULL]) |=>
      (status[usfc_pkg::BIT_OVERRUN] && $stable(st_reg.rx_word)))
    else $error("overrun missed or word replaced");

  a_smartcard_frame: assert property (
    @(posedge core_clk) disable iff (srst)
    (evt.sc_tx_mode && evt.sc_retry_out) |=>
      status[usfc_pkg::BIT_FRAMING])
    else $error("retry exhaustion not flagged");

  a_clear_reads_zero: assert property (
    @(posedge core_clk) disable iff (srst)
    hit(bus.rd, bus.addr, usfc_pkg::OFS_FLAG_CLEAR) |=>
      (rd_data == 32'h0))
    else $error("clear register read not zero");

  a_read_one_cycle: assert property (
    @(posedge core_clk) disable iff (srst)
    !bus.rd |=> (rd_data == 32'h0))
    else $error("read data outside its cycle");

endmodule : usfc_core

// File: design/usfc_pkg.sv
// usfc_pkg: shared offsets, bit positions, reset values and carriers
// for the serial status flag block; used by usfc_core and usfc_irq_gate.
package usfc_pkg;

  // register byte offsets on the plain register port
  localparam logic [7:0] OFS_INT_MASK = 8'h0c;
  localparam logic [7:0] OFS_MODE = 8'h10;
  localparam logic [7:0] OFS_COMMAND = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_FLAG_CLEAR = 8'h20;
  localparam logic [7:0] OFS_RX_WORD = 8'h24;
  localparam logic [7:0] OFS_TX_WORD = 8'h28;

  // status flag positions, shared by status, clear and mask layouts
  localparam int BIT_PARITY = 0;
  localparam int BIT_FRAMING = 1;
  localparam int BIT_NOISE = 2;
  localparam int BIT_OVERRUN = 3;
  localparam int BIT_IDLE = 4;
  localparam int BIT_RX_FULL = 5;
  localparam int BIT_TX_DONE = 6;
  localparam int BIT_TX_EMPTY = 7;
  localparam int BIT_LINE_BREAK = 8;
  localparam int BIT_CTS_CHANGE = 9;
  localparam int BIT_RX_TIMEOUT = 11;
  localparam int BIT_END_BLOCK = 12;
  localparam int BIT_ADDR_MATCH = 17;
  localparam int BIT_WAKEUP = 20;

  // command and mode register bits
  localparam int CMD_TX_FLUSH = 0;
  localparam int CMD_RX_FLUSH = 1;
  localparam int MODE_ERR_INT_EN = 0;
  localparam int MODE_MULTIBUF = 1;

  // bit groups
  localparam logic [31:0] CLEAR_MASK = 32'h0012_1b5f;
  localparam logic [31:0] FLAG_MASK = 32'h0012_1bff;
  localparam logic [31:0] ERROR_BITS = 32'h0000_000e;
  localparam logic [31:0] MASK_WMASK = 32'h0012_1bf1;

  // values after reset
  localparam logic [31:0] STATUS_RST = 32'h0000_0080;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic IDLE_ARM_RST = 1'b1;

  // one register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } usfc_bus_s;

  // one-cycle events from the frame logic and line watchers
  typedef struct packed {
    logic tx_to_shift;
    logic tx_frame_done;
    logic rx_word_ready;
    logic idle_detect;
    logic noise_detect;
    logic desync_detect;
    logic break_char;
    logic sc_tx_mode;
    logic sc_retry_out;
    logic parity_mismatch;
    logic wakeup_event;
    logic addr_match_event;
    logic end_block_event;
    logic rx_timeout_event;
    logic cts_toggle;
    logic line_break_event;
  } usfc_evt_s;

endpackage : usfc_pkg

// File: design/usfc_flag_bank.sv
// usfc_flag_bank: sticky flags with per-bit set and clear vectors.
// assumes set and clear are one-cycle terms from the same clock domain.
`timescale 1ns/100ps
module usfc_flag_bank #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] KEEP = '1,
  parameter logic [WIDTH-1:0] RST = '0
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] set_v,
  input wire logic [WIDTH-1:0] clr_v,
  output logic [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } usfc_bank_st_s;

  usfc_bank_st_s st_reg;
  usfc_bank_st_s st_next;
  logic [WIDTH-1:0] set_k;

  if (WIDTH < 1 || WIDTH > 32) begin : g_width_chk
    $error("flag bank width out of range");
  end

  assign set_k = set_v & KEEP;
  assign flags = st_reg.flags;

  always_comb begin
    st_next = st_reg;
    st_next.flags = ((st_reg.flags & ~clr_v) | set_k) & KEEP;
  end

  // flag storage
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg.flags <= RST & KEEP;
    end else begin
      st_reg <= st_next;
    end
  end

  a_set_wins_clear: assert property (
    @(posedge core_clk) disable iff (srst)
    (|set_k) |=> ((flags & $past(set_k)) == $past(set_k)))
    else $error("flag set lost");

  a_clear_one_bit: assert property (
    @(posedge core_clk) disable iff (srst)
    (|(clr_v & ~set_k & KEEP)) |=>
      ((flags & $past(clr_v) & ~$past(set_k)) == '0))
    else $error("flag not cleared");

endmodule : usfc_flag_bank

// File: design/usfc_irq_gate.sv
// usfc_irq_gate: folds status flags and enables into one level interrupt.
// assumes status, mask and mode come from registers of the same clock.
`timescale 1ns/100ps
module usfc_irq_gate (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [31:0] status,
  input wire logic [31:0] int_mask,
  input wire logic [1:0] mode,
  output logic irq
);

  typedef struct packed {
    logic irq;
  } usfc_irq_st_s;

  usfc_irq_st_s st_reg;
  usfc_irq_st_s st_next;
  logic err_route;

  assign irq = st_reg.irq;
  assign err_route = mode[usfc_pkg::MODE_MULTIBUF] &
                     mode[usfc_pkg::MODE_ERR_INT_EN];

  always_comb begin
    st_next = st_reg;
    st_next.irq = (|(status & int_mask & ~usfc_pkg::ERROR_BITS))
      | (status[usfc_pkg::BIT_OVERRUN]
         & (int_mask[usfc_pkg::BIT_RX_FULL] | err_route))
      | ((status[usfc_pkg::BIT_NOISE] | status[usfc_pkg::BIT_FRAMING])
         & err_route);
  end

  // interrupt level register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg.irq <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  a_err_int_route: assert property (
    @(posedge core_clk) disable iff (srst)
    (status[usfc_pkg::BIT_NOISE] && err_route) |=> irq)
    else $error("noise interrupt missing");

  a_irq_quiet: assert property (
    @(posedge core_clk) disable iff (srst)
    (((status & int_mask) == 32'h0) && !err_route
      && !(status[usfc_pkg::BIT_OVERRUN]
           && int_mask[usfc_pkg::BIT_RX_FULL])) |=> !irq)
    else $error("interrupt without cause");

endmodule : usfc_irq_gate

// File: sim/usfc_partner.sv
// usfc_partner: far-side serial transceiver model feeding line events.
// assumes fire() is called from one process at a time.
`timescale 1ns/100ps
module usfc_partner #(
  parameter int DLY = 4,
  parameter int FRAME = 6
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic tx_word_load,
  output usfc_pkg::usfc_evt_s evt,
  output logic [8:0] rx_shift_word
);
  logic [15:0] ext_reg = 16'h0;
  logic [15:0] auto_v;
  int cnt_reg = 0;

  initial rx_shift_word = 9'h0;

  // one commanded pulse; the word is inverted once it is no longer valid
  task automatic fire(input logic [15:0] v, input logic [8:0] w);
    @(posedge core_clk);
    ext_reg <= v;
    rx_shift_word <= w;
    @(posedge core_clk);
    ext_reg <= 16'h0;
    rx_shift_word <= ~w;
  endtask : fire

  // shifter timing: wait DLY after a load, then shift FRAME cycles
  always @(posedge core_clk) begin
    if (srst)
      cnt_reg <= 0;
    else if (tx_word_load)
      cnt_reg <= DLY + FRAME;
    else if (cnt_reg > 0)
      cnt_reg <= cnt_reg - 1;
  end

  // move to shifter, then frame done at the end
  assign auto_v = {cnt_reg == FRAME, cnt_reg == 1, 14'h0};
  assign evt = usfc_pkg::usfc_evt_s'(ext_reg | auto_v);
endmodule : usfc_partner

// File: sim/testbench.sv
// testbench: self-checking bench of the serial status flag block.
// assumes the far-side model usfc_partner and the design package.
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  typedef struct packed {
    logic [15:0] ev;
    logic [31:0] flag;
  } usfc_row_s;
  logic core_clk;
  logic srst = 1'h1;
  usfc_pkg::usfc_bus_s bus = '0;
  logic [31:0] rd_data;
  usfc_pkg::usfc_evt_s evt;
  logic [8:0] rx_shift_word;
  logic [8:0] tx_word;
  logic tx_word_load;
  logic tx_buffer_empty;
  logic rx_buffer_full;
  logic irq;
  logic [31:0] got;
  usfc_row_s rows [12];
  int bad_count = 0;
  int n_tests = 0;
  localparam logic [31:0] SRST_V = usfc_pkg::STATUS_RST;

  usfc_core #(.DATA_W(9)) DUT (.core_clk(core_clk), .srst(srst),
    .bus(bus), .rd_data(rd_data), .evt(evt),
    .rx_shift_word(rx_shift_word), .tx_word(tx_word),
    .tx_word_load(tx_word_load), .tx_buffer_empty(tx_buffer_empty),
    .rx_buffer_full(rx_buffer_full), .irq(irq));

  usfc_partner u_far (.core_clk(core_clk), .srst(srst),
    .tx_word_load(tx_word_load), .evt(evt), .rx_shift_word(rx_shift_word));

  // 250 MHz clock
  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end

  // register port write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus <= '{a, d, 1'h1, 1'h0};
    @(posedge core_clk);
    bus.wr <= 1'h0;
  endtask : wr

  // register port read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus <= '{a, 32'h0, 1'h0, 1'h1};
    @(posedge core_clk);
    bus.rd <= 1'h0;
    #1;
    d = rd_data;
  endtask : rd

  // verdict and end of run
  task close_out;
    if (bad_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // watchdog against a hang
  initial begin
    repeat (3000) @(posedge core_clk);
    bad_count++;
    close_out();
  end

  // main sequence
  initial begin
    rows = '{'{16'h0040, 32'h1}, '{16'h0400, 32'h2}, '{16'h0200, 32'h2},
      '{16'h0180, 32'h2}, '{16'h0800, 32'h4}, '{16'h1000, 32'h10},
      '{16'h0020, 32'h100000}, '{16'h0010, 32'h20000},
      '{16'h0008, 32'h1000}, '{16'h0004, 32'h800}, '{16'h0002, 32'h200},
      '{16'h0001, 32'h100}};
    repeat (3) @(posedge core_clk);
    srst <= 1'h0;
    rd(usfc_pkg::OFS_STATUS, got);
    `CHK(got, SRST_V)
    `CHK({tx_buffer_empty, rx_buffer_full, irq}, 3'h4)
    // each event sets its flag; zeros keep it, a one clears it
    foreach (rows[i]) begin
      u_far.fire(rows[i].ev, 9'h0);
      rd(usfc_pkg::OFS_STATUS, got);
      `CHK(got, SRST_V | rows[i].flag)
      wr(usfc_pkg::OFS_FLAG_CLEAR, ~rows[i].flag);
      rd(usfc_pkg::OFS_STATUS, got);
      `CHK(got, SRST_V | rows[i].flag)
      wr(usfc_pkg::OFS_FLAG_CLEAR, rows[i].flag);
      rd(usfc_pkg::OFS_STATUS, got);
      `CHK(got, SRST_V)
      rd(usfc_pkg::OFS_FLAG_CLEAR, got);
      `CHK(got, 32'h0)
      `CHK(irq, 1'h0)
    end
    // idle stays disarmed until rx full sets again
    u_far.fire(16'h1000, 9'h0);
    rd(usfc_pkg::OFS_STATUS, got);
    `CHK(got, SRST_V)
    u_far.fire(16'h2000, 9'h1a5);
    #1;
    `CHK(rx_buffer_full, 1'h1)
    u_far.fire(16'h2000, 9'h0aa);
    rd(usfc_pkg::OFS_STATUS, got);
    `CHK(got, 32'h0000_00a8)
    rd(usfc_pkg::OFS_RX_WORD, got);
    `CHK(got, 32'h0000_01a5)
    `CHK(rx_buffer_full, 1'h0)
    u_far.fire(16'h1000, 9'h0);
    rd(usfc_pkg::OFS_STATUS, got);
    `CHK(got, 32'h0000_0098)
    // overrun interrupt follows the rx full enable
    wr(usfc_pkg::OFS_INT_MASK, 32'h20);
    @(posedge core_clk);
    #1;
    `CHK(irq, 1'h1)
    wr(usfc_pkg::OFS_INT_MASK, 32'h0);
    wr(usfc_pkg::OFS_FLAG_CLEAR, 32'h18);
    // rx flush command
    u_far.fire(16'h2000, 9'h055);
    wr(usfc_pkg::OFS_COMMAND, 32'h2);
    #1;
    `CHK(rx_buffer_full, 1'h0)
    // tx word, early frame end ignored, then the far side shifts it
    wr(usfc_pkg::OFS_TX_WORD, 32'h1c3);
    #1;
    `CHK({tx_buffer_empty, tx_word_load, tx_word}, 11'h3c3)
    u_far.fire(16'h4000, 9'h0);
    rd(usfc_pkg::OFS_STATUS, got);
    `CHK(got, 32'h0)
    repeat (12) @(posedge core_clk);
    rd(usfc_pkg::OFS_STATUS, got);
    `CHK(got, 32'h0000_00c0)
    wr(usfc_pkg::OFS_INT_MASK, 32'h40);
    rd(usfc_pkg::OFS_INT_MASK, got);
    `CHK({got, irq}, {32'h40, 1'h1})
    wr(usfc_pkg::OFS_FLAG_CLEAR, 32'h40);
    @(posedge core_clk);
    #1;
    `CHK(irq, 1'h0)
    wr(usfc_pkg::OFS_COMMAND, 32'h1);
    // tx flush with empty already set keeps it
    #1;
    `CHK(tx_buffer_empty, 1'h1)
    // set and clear of parity in the same cycle
    fork
      u_far.fire(16'h0040, 9'h0);
      wr(usfc_pkg::OFS_FLAG_CLEAR, 32'h1);
    join
    rd(usfc_pkg::OFS_STATUS, got);
    `CHK(got, 32'h0000_0081)
    // multibuffer error interrupt
    wr(usfc_pkg::OFS_INT_MASK, 32'h0);
    wr(usfc_pkg::OFS_MODE, 32'h3);
    u_far.fire(16'h0800, 9'h0);
    @(posedge core_clk);
    #1;
    `CHK(irq, 1'h1)
    wr(usfc_pkg::OFS_MODE, 32'h0);
    @(posedge core_clk);
    #1;
    `CHK(irq, 1'h0)
    wr(usfc_pkg::OFS_INT_MASK, 32'h1);
    @(posedge core_clk);
    #1;
    `CHK(irq, 1'h1)
    // status is read only, unmapped reads give zero
    wr(usfc_pkg::OFS_STATUS, 32'hffff_ffff);
    rd(8'h3c, got);
    `CHK(got, 32'h0)
    // second reset in mid-run
    @(posedge core_clk);
    srst <= 1'h1;
    @(posedge core_clk);
    srst <= 1'h0;
    rd(usfc_pkg::OFS_STATUS, got);
    `CHK({got, irq}, {SRST_V, 1'h0})
    rd(usfc_pkg::OFS_INT_MASK, got);
    `CHK(got, usfc_pkg::MASK_RST)
    close_out();
  end
endmodule : testbench
